/* hdl/stpc_defines.svh */
// Constants for the scan test port and pin-state control block
`ifndef STPC_DEFINES_SVH
`define STPC_DEFINES_SVH

// APB byte offsets
`define STPC_OFS_BUSCTL 12'h000
`define STPC_OFS_EGC1   12'h004
`define STPC_OFS_EGC2   12'h008
`define STPC_OFS_STAT   12'h00C

// External bus control register fields
`define STPC_XB_HOLDER  0
`define STPC_XB_PULLUP  1
`define STPC_XB_PULLDN  2
`define STPC_XB_EMUPU   3
`define STPC_XB_RST     4'hF

// Global control fields: clock-out hold tristate bit
`define STPC_EG_HZ      0
`define STPC_EG_RST     1'h0

// Status register fields
`define STPC_ST_HOLD    0
`define STPC_ST_RESET   1
`define STPC_ST_OFF     2
`define STPC_ST_SCAN    3
`define STPC_ST_TRST    4

// Synchroniser slots for pin inputs
`define STPC_SY_HOLD    0
`define STPC_SY_RST     1
`define STPC_SY_EPZERO  2
`define STPC_SY_EPONE   3
`define STPC_SY_TRST    4
// Idle pin levels loaded into the synchronisers at reset
`define STPC_SY_IDLE    5'h0F

// Instruction codes and capture pattern
`define STPC_IR_IDCODE  4'h1
`define STPC_IR_BYPASS  4'hF
`define STPC_IR_CAPT    4'h1
// Identity code (value is arbitrary)
`define STPC_ID_DEFAULT 32'h0ACE_0001

`endif

/* hdl/stpc_pkg.sv */
// Types for the scan test port and pin-state control block
package stpc_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
    TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } stpc_tap_e;

  // System clock domain state
  typedef struct packed {
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic        scan_m;
    logic        scan_s;
    logic [3:0]  bus_ctrl;
    logic [1:0]  clk_hz;
    logic [1:0]  mclk;
    logic [1:0]  mclk_oe;
    logic        off_z;
    logic        hold_z;
    logic        rst_z;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } stpc_sys_s;

  // Test clock domain state (rising edge)
  typedef struct packed {
    logic        trst_m;
    logic        trst_s;
    stpc_tap_e   state;
    logic [3:0]  ir_sh;
    logic [3:0]  ir;
    logic [31:0] dr_sh;
    logic        scan;
  } stpc_tck_s;

  // Test data output state (falling edge)
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } stpc_tdo_s;

endpackage

/* hdl/stpc_top.sv */
// Scan test port with device pin-state control and APB register access
//
// Contract
// - Test mode select and test data in are taken on each rising test clock edge.
// - Test data out changes only on falling test clock edges, shifting the selected register.
// - Test data out is high impedance except while a register is shifting.
// - Test reset high hands control to the scan logic; low runs functional mode, ignoring it.
// - Off-flagged pins float when test reset is 0, emulation pin zero 1 and pin one 0.
// - In hold, each memory clock keeps toggling if its hold tristate bit is 0, else floats.
// - Hold-flagged pins float whenever hold mode is entered through the hold request pin.
// - Reset-flagged pins float for as long as the hardware reset pin is low.
// - Bus holders are switched through the external bus control register, on after reset.
// - Configurable pull resistors are switched through that register, on after reset.
`timescale 1ns/1ps
`include "stpc_defines.svh"

module stpc_top
  import stpc_pkg::*;
#(
  parameter logic [31:0] ID_CODE = `STPC_ID_DEFAULT
) (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  input  wire logic        trst_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  input  wire logic        emulation_pin_zero_i,
  input  wire logic        emulation_pin_one_output_disable_n_i,
  input  wire logic        hold_req_n_i,
  input  wire logic        hw_reset_n_i,
  output logic             off_tristate_o,
  output logic             hold_tristate_o,
  output logic             reset_tristate_o,
  output logic      [1:0]  memory_clock_out_o,
  output logic      [1:0]  memory_clock_oe_o,
  output logic             bus_holder_en_o,
  output logic             pull_up_en_o,
  output logic             pull_down_en_o,
  output logic             emu_pull_up_en_o
);

  // Synchronisers leave reset at the idle pin levels, so no false hold or reset follows
  localparam stpc_sys_s SYS_RST = '{s1: `STPC_SY_IDLE, s2: `STPC_SY_IDLE, bus_ctrl: `STPC_XB_RST,
                                    clk_hz: {2{`STPC_EG_RST}}, rst_z: 1'b1, default: '0};

  stpc_sys_s sys_q;
  stpc_sys_s sys_d;
  stpc_tck_s tck_q;
  stpc_tck_s tck_d;
  stpc_tdo_s neg_q;
  stpc_tdo_s neg_d;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // System domain: pin synchronisers, pin-state control, APB slave

  // Next state of the system domain
  always_comb begin
    logic       hold_act;
    logic       rst_act;
    logic       off_act;
    logic       acc;
    logic       hit;
    logic [31:0] rd;
    hold_act = 1'b0;
    rst_act  = 1'b0;
    off_act  = 1'b0;
    acc      = 1'b0;
    hit      = 1'b0;
    rd       = 32'h0000_0000;
    sys_d    = sys_q;
    // Two flops on every pin input before use
    sys_d.s1     = {trst_i, emulation_pin_one_output_disable_n_i, emulation_pin_zero_i,
                    hw_reset_n_i, hold_req_n_i};
    sys_d.s2     = sys_q.s1;
    sys_d.scan_m = tck_q.scan;
    sys_d.scan_s = sys_q.scan_m;
    hold_act = !sys_q.s2[`STPC_SY_HOLD];
    rst_act  = !sys_q.s2[`STPC_SY_RST];
    // Off condition only while scan logic is not in control
    off_act  = !sys_q.s2[`STPC_SY_TRST] && sys_q.s2[`STPC_SY_EPZERO]
               && !sys_q.s2[`STPC_SY_EPONE];
    sys_d.off_z  = off_act;
    sys_d.hold_z = hold_act;
    sys_d.rst_z  = rst_act;
    // Memory clocks run free; only the enable follows hold
    sys_d.mclk = ~sys_q.mclk;
    for (int i = 0; i < 2; i++) begin
      sys_d.mclk_oe[i] = !(hold_act && sys_q.clk_hz[i]);
    end
    // Register read data and address decode
    unique case (paddr_i)
      `STPC_OFS_BUSCTL: begin
        hit = 1'b1;
        rd[3:0] = sys_q.bus_ctrl;
      end
      `STPC_OFS_EGC1: begin
        hit = 1'b1;
        rd[`STPC_EG_HZ] = sys_q.clk_hz[0];
      end
      `STPC_OFS_EGC2: begin
        hit = 1'b1;
        rd[`STPC_EG_HZ] = sys_q.clk_hz[1];
      end
      `STPC_OFS_STAT: begin
        hit = 1'b1;
        rd[`STPC_ST_HOLD]  = hold_act;
        rd[`STPC_ST_RESET] = rst_act;
        rd[`STPC_ST_OFF]   = off_act;
        rd[`STPC_ST_SCAN]  = sys_q.scan_s;
        rd[`STPC_ST_TRST]  = sys_q.s2[`STPC_SY_TRST];
      end
      default: hit = 1'b0;
    endcase
    // One wait state: answer in the second access cycle
    acc = psel_i && penable_i;
    sys_d.pready = acc && !sys_q.pready;
    if (acc && !sys_q.pready) begin
      sys_d.pslverr = !hit;
      sys_d.prdata  = (pwrite_i || !hit) ? 32'h0000_0000 : rd;
    end else begin
      sys_d.pslverr = 1'b0;
      sys_d.prdata  = 32'h0000_0000;
    end
    // Writes land on the completing edge
    if (acc && sys_q.pready && pwrite_i) begin
      unique case (paddr_i)
        `STPC_OFS_BUSCTL: sys_d.bus_ctrl = pwdata_i[3:0];
        `STPC_OFS_EGC1: sys_d.clk_hz[0] = pwdata_i[`STPC_EG_HZ];
        `STPC_OFS_EGC2: sys_d.clk_hz[1] = pwdata_i[`STPC_EG_HZ];
        default: sys_d.bus_ctrl = sys_q.bus_ctrl;
      endcase
    end
  end

  // System domain register
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sys_q <= SYS_RST;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign prdata_o           = sys_q.prdata;
  assign pready_o           = sys_q.pready;
  assign pslverr_o          = sys_q.pslverr;
  assign off_tristate_o     = sys_q.off_z;
  assign hold_tristate_o    = sys_q.hold_z;
  assign reset_tristate_o   = sys_q.rst_z;
  assign memory_clock_out_o = sys_q.mclk;
  assign memory_clock_oe_o  = sys_q.mclk_oe;
  assign bus_holder_en_o    = sys_q.bus_ctrl[`STPC_XB_HOLDER];
  assign pull_up_en_o       = sys_q.bus_ctrl[`STPC_XB_PULLUP];
  assign pull_down_en_o     = sys_q.bus_ctrl[`STPC_XB_PULLDN];
  assign emu_pull_up_en_o   = sys_q.bus_ctrl[`STPC_XB_EMUPU];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Test clock domain: TAP controller and scan registers

  // Next state of the TAP on the rising test clock edge
  always_comb begin
    logic is_id;
    is_id  = (tck_q.ir == `STPC_IR_IDCODE);
    tck_d  = tck_q;
    tck_d.trst_m = trst_i;
    tck_d.trst_s = tck_q.trst_m;
    if (!tck_q.trst_s) begin
      // Functional mode: scan inputs are ignored
      tck_d.state = TAP_RESET;
      tck_d.ir    = `STPC_IR_IDCODE;
    end else begin
      unique case (tck_q.state)
        TAP_RESET: begin
          tck_d.state = tms_i ? TAP_RESET : TAP_IDLE;
          tck_d.ir    = `STPC_IR_IDCODE;
        end
        TAP_IDLE:     tck_d.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   tck_d.state = tms_i ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: begin
          tck_d.state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
          tck_d.dr_sh = is_id ? ID_CODE : 32'h0000_0000;
        end
        TAP_SHIFT_DR: begin
          tck_d.state = tms_i ? TAP_EXIT1_DR : TAP_SHIFT_DR;
          if (is_id) begin
            tck_d.dr_sh = {tdi_i, tck_q.dr_sh[31:1]};
          end else begin
            tck_d.dr_sh[0] = tdi_i;
          end
        end
        TAP_EXIT1_DR: tck_d.state = tms_i ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: tck_d.state = tms_i ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: tck_d.state = tms_i ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR:   tck_d.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   tck_d.state = tms_i ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: begin
          tck_d.state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
          tck_d.ir_sh = `STPC_IR_CAPT;
        end
        TAP_SHIFT_IR: begin
          tck_d.state = tms_i ? TAP_EXIT1_IR : TAP_SHIFT_IR;
          tck_d.ir_sh = {tdi_i, tck_q.ir_sh[3:1]};
        end
        TAP_EXIT1_IR: tck_d.state = tms_i ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: tck_d.state = tms_i ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: tck_d.state = tms_i ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: begin
          tck_d.state = tms_i ? TAP_SEL_DR : TAP_IDLE;
          tck_d.ir    = tck_q.ir_sh;
        end
      endcase
    end
    tck_d.scan = tck_q.trst_s && (tck_d.state != TAP_RESET);
  end

  // Test clock register; test reset is the synchronous reset here
  always_ff @(posedge tck_i) begin
    tck_q <= tck_d;
  end

  // Output stage, launched on the falling edge
  always_comb begin
    neg_d.tdo_oe = tck_q.trst_s && ((tck_q.state == TAP_SHIFT_DR)
                   || (tck_q.state == TAP_SHIFT_IR));
    neg_d.tdo    = (tck_q.state == TAP_SHIFT_IR) ? tck_q.ir_sh[0] : tck_q.dr_sh[0];
  end

  // Falling edge register for test data out
  always_ff @(negedge tck_i) begin
    if (!tck_q.trst_s) begin
      neg_q <= '0;
    end else begin
      neg_q <= neg_d;
    end
  end

  assign tdo_o    = neg_q.tdo;
  assign tdo_oe_o = neg_q.tdo_oe;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_tap_held_reset: assert property (@(posedge tck_i)
    !tck_q.trst_s |=> tck_q.state == TAP_RESET)
    else $error("TAP left reset while test reset low");

  chk_ir_shift_in: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tck_q.state == TAP_SHIFT_IR |=> tck_q.ir_sh[3] == $past(tdi_i))
    else $error("Instruction shift did not take test data in");

  chk_tdo_shift_bit: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tdo_oe_o && tck_q.state == TAP_SHIFT_IR |-> tdo_o == tck_q.ir_sh[0])
    else $error("Test data out not the selected register bit");

  chk_tdo_float: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tdo_oe_o |-> (tck_q.state == TAP_SHIFT_DR || tck_q.state == TAP_SHIFT_IR))
    else $error("Test data out driven outside shifting");

  chk_ir_update: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tck_q.state == TAP_UPD_IR |=> tck_q.ir == $past(tck_q.ir_sh))
    else $error("Instruction not updated");

  chk_off_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (!trst_i && emulation_pin_zero_i && !emulation_pin_one_output_disable_n_i) [*3]
      |=> off_tristate_o)
    else $error("Off condition did not float pins");

  chk_hold_clock: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sys_q.s2[`STPC_SY_HOLD] && !sys_q.clk_hz[0] |=>
      memory_clock_oe_o[0] && memory_clock_out_o[0] != $past(memory_clock_out_o[0]))
    else $error("Memory clock stopped or floated in hold");

  chk_hold_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(hold_req_n_i) ##1 !hold_req_n_i [*2] |-> ##1 hold_tristate_o)
    else $error("Hold request did not float pins");

  chk_reset_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !hw_reset_n_i [*3] |=> reset_tristate_o)
    else $error("Reset pin low but pins driven");

  chk_holder_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == `STPC_OFS_BUSCTL
      |=> bus_holder_en_o == $past(pwdata_i[`STPC_XB_HOLDER]))
    else $error("Bus holder enable not written");

  chk_pull_reset: assert property (@(posedge clk_sys_i)
    $fell(reset_i) |-> pull_up_en_o && pull_down_en_o && bus_holder_en_o && emu_pull_up_en_o)
    else $error("Pulls or holder not enabled after reset");

  // Further scan side checks
  chk_dr_shift_in: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tck_q.state == TAP_SHIFT_DR && tck_q.ir == `STPC_IR_IDCODE
      |=> tck_q.dr_sh[31] == $past(tdi_i))
    else $error("Data shift did not take test data in");

  chk_tdo_dr_bit: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tdo_oe_o && tck_q.state == TAP_SHIFT_DR |-> tdo_o == tck_q.dr_sh[0])
    else $error("Test data out not the data register bit");

  chk_tdo_reset_off: assert property (@(posedge tck_i)
    !tck_q.trst_s && !tck_q.trst_m |=> !tdo_oe_o)
    else $error("Test data out driven while test reset low");

  chk_tms_reset: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tms_i [*5] |=> tck_q.state == TAP_RESET)
    else $error("Five select ones did not reach reset");

  chk_ir_capture: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tck_q.state == TAP_CAP_IR |=> tck_q.ir_sh == `STPC_IR_CAPT)
    else $error("Instruction capture pattern wrong");

  chk_bypass_capture: assert property (@(posedge tck_i) disable iff (!tck_q.trst_s)
    tck_q.state == TAP_CAP_DR && tck_q.ir != `STPC_IR_IDCODE |=> tck_q.dr_sh == 32'h0000_0000)
    else $error("Bypass did not capture zero");

  // Further pin side checks
  chk_clock_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !sys_q.s2[`STPC_SY_HOLD] && sys_q.clk_hz[0] |=> !memory_clock_oe_o[0])
    else $error("Memory clock not floated in hold");

  chk_hold_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    hold_req_n_i [*3] |=> !hold_tristate_o)
    else $error("Hold pins floated without hold request");

  chk_off_scan: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    trst_i [*3] |=> !off_tristate_o)
    else $error("Off condition active while scan in control");

  chk_reset_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    hw_reset_n_i [*3] |=> !reset_tristate_o)
    else $error("Reset pins floated with reset pin high");

  chk_pull_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    psel_i && penable_i && pready_o && pwrite_i && paddr_i == `STPC_OFS_BUSCTL
      |=> pull_up_en_o == $past(pwdata_i[`STPC_XB_PULLUP]))
    else $error("Pull-up enable not written");

endmodule

/* test/stpc_tester.sv */
// Behavioural scan tester driving the device test port from outside
`timescale 1ns/1ps

module stpc_tester (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  int   slips;     // Times tdo moved away from a falling edge
  int   oe_rises;  // Rising edges that saw the output enabled
  logic tdo_last;

  // Clock rests low between frames; pulled-up select and data idle high
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b1;
    trst_o   = 1'b0;
    slips    = 0;
    oe_rises = 0;
    tdo_last = 1'b0;
  end

  // One 32 ns period: inputs set while low, output taken on the rise; a floating pin reads inverted
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #8 tck_o = 1'b1;
    tdo = (tdo_oe_i === 1'b1) ? tdo_i : ~tdo_i;
    if (tdo_oe_i === 1'b1) oe_rises++;
    if (tdo_oe_i === 1'b1 && tdo_i !== tdo_last) slips++;
    #16 tck_o = 1'b0;
    #1 tdo_last = tdo_i;
    #7;
  endtask

  // Test reset held low with the clock running, then left low or raised
  task automatic tap_reset(input logic keep_low);
    logic d;
    trst_o = 1'b0;
    repeat (4) tick(1'b1, 1'b1, d);
    trst_o = ~keep_low;
    repeat (5) tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
  endtask

  // From idle, scan n bits through the data or instruction path, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output int oe_cnt);
    logic d;
    dout = '0;
    oe_rises = 0;
    tick(1'b1, 1'b1, d);
    if (ir) tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    tick(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], d);
      dout[i] = d;
    end
    tick(1'b1, 1'b1, d);
    tick(1'b0, 1'b1, d);
    oe_cnt = oe_rises;
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the scan port and pin-state control block
`timescale 1ns/1ps
`include "stpc_defines.svh"

module tb_top;
  localparam logic [31:0] TEST_ID = 32'h1234_5679; // Arbitrary identity value, bit 0 set
  localparam logic [11:0] BUS_OFS = `STPC_OFS_BUSCTL;
  logic        clk_sys, reset, psel, penable, pwrite, epin_zero, epin_one_off_n;
  logic        hold_req_n, hw_reset_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, tck, tms, tdi, trst, tdo, tdo_oe;
  logic        off_tz, hold_tz, rst_tz, holder, pu, pd, emu_pu;
  logic [1:0]  mclk, mclk_oe;
  int          errors, n_checks, cyc, oe_cnt;

  stpc_top #(.ID_CODE(TEST_ID)) stpc_top_i (
    .clk_sys_i(clk_sys), .reset_i(reset), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_i(trst), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .emulation_pin_zero_i(epin_zero),
    .emulation_pin_one_output_disable_n_i(epin_one_off_n), .hold_req_n_i(hold_req_n),
    .hw_reset_n_i(hw_reset_n),
    .off_tristate_o(off_tz), .hold_tristate_o(hold_tz), .reset_tristate_o(rst_tz),
    .memory_clock_out_o(mclk), .memory_clock_oe_o(mclk_oe), .bus_holder_en_o(holder),
    .pull_up_en_o(pu), .pull_down_en_o(pd), .emu_pull_up_en_o(emu_pu));

  stpc_tester stpc_tester_i (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_o(trst),
    .tdo_i(tdo), .tdo_oe_i(tdo_oe));

  // System clock, 4 ns period
  initial clk_sys = 1'b0;
  always #2 clk_sys = ~clk_sys;

  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // Compare one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Let n system edges pass, then settle
  task automatic edges(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // One APB transfer; waits for pready, only the hang guard ends the wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reset defaults, register access and an unmapped address
  task automatic t_regs();
    chk("pull enables", 32'hF, {emu_pu, pd, pu, holder});
    apb(1'b0, BUS_OFS, 32'h0);
    chk("bus ctrl reset", 32'hF, rd);
    apb(1'b1, BUS_OFS, 32'h5);
    apb(1'b0, BUS_OFS, 32'h0);
    chk("bus ctrl back", 32'h5, rd);
    edges(2);
    chk("pull enables w", 32'h5, {emu_pu, pd, pu, holder});
    apb(1'b1, BUS_OFS, 32'hF);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask

  // Output-disable truth table with test reset low
  task automatic t_off();
    for (int k = 0; k < 4; k++) begin
      epin_zero <= k[0];
      epin_one_off_n <= k[1];
      edges(4);
      chk("off tristate", {31'h0, k == 1}, {31'h0, off_tz});
    end
    $display("test off done");
  endtask

  // Hold request with clock 0 floated and clock 1 running
  task automatic t_hold();
    logic [1:0] a;
    apb(1'b1, `STPC_OFS_EGC1, 32'h1);
    apb(1'b1, `STPC_OFS_EGC2, 32'h0);
    hold_req_n <= 1'b0;
    edges(4);
    chk("hold tristate", 32'h1, {31'h0, hold_tz});
    chk("clock enables", 32'h2, {30'h0, mclk_oe});
    a = mclk;
    edges(1);
    chk("clock 1 toggles", {31'h0, ~a[1]}, {31'h0, mclk[1]});
    hold_req_n <= 1'b1;
    edges(4);
    chk("hold released", 32'h3, {29'h0, hold_tz, mclk_oe});
    $display("test hold done");
  endtask

  // Hardware reset pin floats reset-flagged pins while low
  task automatic t_hwrst();
    hw_reset_n <= 1'b0;
    edges(4);
    chk("reset tristate", 32'h1, {31'h0, rst_tz});
    hw_reset_n <= 1'b1;
    edges(4);
    chk("reset released", 32'h0, {31'h0, rst_tz});
    $display("test hw reset done");
  endtask

  // Identity read, instruction capture, bypass path
  task automatic t_scan();
    stpc_tester_i.tap_reset(1'b0);
    stpc_tester_i.scan(1'b0, 32, 32'h0, rd, oe_cnt);
    chk("identity", TEST_ID, rd);
    chk("dr oe rises", 32'd32, oe_cnt);
    stpc_tester_i.scan(1'b1, 4, {28'h0, `STPC_IR_BYPASS}, rd, oe_cnt);
    chk("ir capture", 32'h1, rd);
    chk("ir oe rises", 32'd4, oe_cnt);
    stpc_tester_i.scan(1'b0, 8, 32'hA5, rd, oe_cnt);
    chk("bypass", 32'h4A, rd);
    chk("edge slips", 32'd0, stpc_tester_i.slips);
    apb(1'b0, `STPC_OFS_STAT, 32'h0);
    chk("status scan", 32'h18, rd);
    epin_one_off_n <= 1'b0;
    edges(4);
    chk("off with scan", 32'h0, {31'h0, off_tz});
    epin_one_off_n <= 1'b1;
    $display("test scan done");
  endtask

  // Test reset low: scan inputs have no effect
  task automatic t_ignore();
    stpc_tester_i.tap_reset(1'b1);
    stpc_tester_i.scan(1'b0, 32, 32'h0, rd, oe_cnt);
    chk("ignored oe rises", 32'd0, oe_cnt);
    chk("tdo enable", 32'h0, {31'h0, tdo_oe});
    apb(1'b0, `STPC_OFS_STAT, 32'h0);
    chk("status ignore", 32'h0, rd);
    $display("test ignore done");
  endtask

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    errors = 0;
    n_checks = 0;
    cyc = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    epin_zero = 1'b1;
    epin_one_off_n = 1'b1;
    hold_req_n = 1'b1;
    hw_reset_n = 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    edges(4);
    t_regs();
    t_off();
    t_hold();
    t_hwrst();
    t_scan();
    t_ignore();
    wrap_up();
  end
endmodule
